// [design/clk_pwr_ctrl.sv]
// Reset, sleep and power-down control for the clock distribution outputs
//
// Behaviour
// - CMOS mode turns first output on automatically
// - Each of four channels LVDS or two CMOS
// - Three-bit CMOS polarity field per channel
// - LVDS polarity selectable per channel
// - One power-down bit kills whole channel
// - Power-up loads defaults then syncs outputs
// - Reset pin low restores all register defaults
// - Mirrored soft reset bits set, then cleared
// - Soft reset acts without update operation
// - Sleep pin holds sleep; wake restores settings
// - Sleep turns off PLL, VCO, buffers, outputs
// - Register port keeps working during sleep
// - Async PLL mode powers down on update
// - Sync PLL mode waits charge pump event
// - Distribution power-down removes distribution bias
// - PECL codes: 00 normal, 10 safe, 11 total
// - Every output individually powered down
// - Clock buffer and references own power-down
// - Update bit copies shadow to active
// - Reset or sleep release triggers output sync
//
// The address map and the plain strobed port were chosen for this implementation.
module clk_pwr_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter int SYNC_CYCLES = SYNC_HOLD_CYC
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic chip_sleep_pin_n_in,
  input wire logic cp_event_in,
  input wire logic [clk_ctrl_pkg::ADDR_W-1:0] addr_in,
  input wire logic [clk_ctrl_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [clk_ctrl_pkg::DATA_W-1:0] rdata_out,
  output logic pll_pd_out,
  output logic vco_pd_out,
  output logic clk_buf_pd_out,
  output logic ref_one_pd_out,
  output logic ref_two_pd_out,
  output logic dividers_pd_out,
  output logic dist_bias_off_out,
  output logic [clk_ctrl_pkg::NUM_PECL*2-1:0] pecl_pd_mode_out,
  output logic [clk_ctrl_pkg::NUM_CH-1:0] lvds_en_out,
  output logic [clk_ctrl_pkg::NUM_CH-1:0] lvds_invert_out,
  output logic [clk_ctrl_pkg::NUM_CH-1:0] cmos_first_en_out,
  output logic [clk_ctrl_pkg::NUM_CH-1:0] cmos_second_en_out,
  output logic [clk_ctrl_pkg::NUM_CH*3-1:0] cmos_pol_out,
  output logic sync_out
);
  import clk_ctrl_pkg::*;

  localparam int NREG = NUM_CH + NUM_PECL + 4;
  localparam int IDX_PORT = 0;
  localparam int IDX_PLL = 1;
  localparam int IDX_BLK = 2;
  localparam int IDX_DIST = 3;
  localparam int IDX_PECL = 4;
  localparam int IDX_LVDS = IDX_PECL + NUM_PECL;

  function automatic logic [9:0] reg_addr(input int idx);
    logic [9:0] a;
    a = 10'h000;
    if (idx == IDX_PORT) a = REG_PORT_CFG;
    else if (idx == IDX_PLL) a = REG_PLL_CFG;
    else if (idx == IDX_BLK) a = REG_BLOCK_PD;
    else if (idx == IDX_DIST) a = REG_DIST_CTRL;
    else if (idx < IDX_LVDS) a = REG_PECL_BASE + 10'(idx - IDX_PECL);
    else a = REG_LVDS_BASE + 10'(idx - IDX_LVDS);
    return a;
  endfunction

  function automatic logic [7:0] reg_rst(input int idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_PORT) v = PORT_CFG_RST;
    else if (idx == IDX_PLL) v = PLL_CFG_RST;
    else if (idx == IDX_BLK) v = BLOCK_PD_RST;
    else if (idx == IDX_DIST) v = DIST_CTRL_RST;
    else if (idx < IDX_LVDS) v = PECL_RST;
    else v = LVDS_RST;
    return v;
  endfunction

  // Pin synchronisers: three stages, change accepted when 2nd and 3rd agree
  logic [2:0] rst_sync_q;
  logic [2:0] sleep_sync_q;
  logic sleep_q;
  logic awake_q;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 3'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[1:0], 1'b1};
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sleep_sync_q <= 3'h0;
      sleep_q <= 1'b1;
    end else begin
      sleep_sync_q <= {sleep_sync_q[1:0], chip_sleep_pin_n_in};
      if (sleep_sync_q[1] == sleep_sync_q[2]) begin
        sleep_q <= !sleep_sync_q[2];
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      awake_q <= 1'b0;
    end else if (rst_sync_q[1] && rst_sync_q[2]) begin
      awake_q <= 1'b1;
    end
  end

  // Register port stays live in sleep; reset pin stops it, soft reset blocks writes to all but port config
  logic [NREG-1:0] wr_hit;
  logic [NREG-1:0][7:0] shadow;
  logic [NREG-1:0][7:0] active;
  logic soft_rst;
  logic update_pulse;

  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      wr_hit[i] = wr_in && (addr_in == reg_addr(i));
    end
  end

  // Both mirrored bits must be set; the bit stays until host clears it
  assign soft_rst = shadow[IDX_PORT][PORT_SRST_LO] && shadow[IDX_PORT][PORT_SRST_HI];
  // Self-clearing: a pulse only in the write cycle, never stored
  assign update_pulse = wr_in && (addr_in == REG_UPDATE) && wdata_in[UPDATE_BIT];

  for (genvar g = 0; g < NREG; g++) begin : g_reg
    // Port config byte never waits for update, so soft reset bits act directly
    cfg_reg_bank #(
      .WIDTH(8),
      .RST_VAL(reg_rst(g))
    ) u_bank (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .clear_in((g == IDX_PORT) ? 1'b0 : soft_rst),
      .wr_in(wr_hit[g]),
      .wdata_in(wdata_in),
      .update_in((g == IDX_PORT) ? wr_hit[g] : update_pulse),
      .shadow_out(shadow[g]),
      .active_out(active[g])
    );
  end

  // Sequencer
  seq_state_t state_q;
  logic [15:0] sync_cnt_q;
  logic srst_seen_q;
  logic soft_sync_q;
  logic dist_pd_q;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      srst_seen_q <= 1'b0;
    end else begin
      srst_seen_q <= soft_rst;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      soft_sync_q <= 1'b0;
      dist_pd_q <= 1'b0;
    end else begin
      soft_sync_q <= active[IDX_DIST][DIST_SYNC_BIT];
      dist_pd_q <= active[IDX_DIST][DIST_PD_BIT];
    end
  end

  logic resync_req;
  // Set-then-clear of soft reset, soft sync or distribution power-down
  assign resync_req = (srst_seen_q && !soft_rst) ||
                      (soft_sync_q && !active[IDX_DIST][DIST_SYNC_BIT]) ||
                      (dist_pd_q && !active[IDX_DIST][DIST_PD_BIT]);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= SEQ_RESET;
      sync_cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        SEQ_RESET: begin
          // Defaults already active; sync on leaving reset or power-up
          if (awake_q) begin
            state_q <= SEQ_SYNC;
            sync_cnt_q <= 16'(SYNC_CYCLES);
          end
        end
        SEQ_SYNC: begin
          if (sleep_q) begin
            state_q <= SEQ_SLEEP;
          end else if (sync_cnt_q <= 16'h0001) begin
            state_q <= SEQ_RUN;
            sync_cnt_q <= 16'h0000;
          end else begin
            sync_cnt_q <= sync_cnt_q - 16'h0001;
          end
        end
        SEQ_RUN: begin
          if (sleep_q) begin
            state_q <= SEQ_SLEEP;
          end else if (resync_req) begin
            state_q <= SEQ_SYNC;
            sync_cnt_q <= 16'(SYNC_CYCLES);
          end
        end
        SEQ_SLEEP: begin
          // Wake resumes the active copy, including writes that were updated while asleep
          if (!sleep_q) begin
            state_q <= SEQ_SYNC;
            sync_cnt_q <= 16'(SYNC_CYCLES);
          end
        end
      endcase
    end
  end

  // PLL power-down: async acts on update, sync waits for charge pump event
  logic pll_mode_pd_q;
  logic [1:0] pll_mode;
  assign pll_mode = active[IDX_PLL][PLL_MODE_LSB +: 2];

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pll_mode_pd_q <= 1'b1;
    end else if (pll_mode == PLL_PD_ASYNC) begin
      pll_mode_pd_q <= 1'b1;
    end else if (pll_mode == PLL_PD_SYNC) begin
      if (cp_event_in) begin
        pll_mode_pd_q <= 1'b1;
      end
    end else begin
      pll_mode_pd_q <= 1'b0;
    end
  end

  logic asleep;
  logic dist_off;
  assign asleep = (state_q == SEQ_SLEEP) || (state_q == SEQ_RESET);
  assign dist_off = active[IDX_DIST][DIST_PD_BIT];

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pll_pd_out <= 1'b1;
      vco_pd_out <= 1'b1;
      clk_buf_pd_out <= 1'b1;
      ref_one_pd_out <= 1'b1;
      ref_two_pd_out <= 1'b1;
      dividers_pd_out <= 1'b1;
      dist_bias_off_out <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      pll_pd_out <= asleep || pll_mode_pd_q;
      vco_pd_out <= asleep || pll_mode_pd_q;
      clk_buf_pd_out <= asleep || active[IDX_BLK][BLK_CLK_PD_BIT];
      ref_one_pd_out <= asleep || active[IDX_BLK][BLK_REFERENCE_INPUT_ONE_PD_BIT];
      ref_two_pd_out <= asleep || active[IDX_BLK][BLK_REFERENCE_INPUT_TWO_PD_BIT];
      dividers_pd_out <= asleep || dist_off;
      dist_bias_off_out <= dist_off;
      sync_out <= (state_q != SEQ_RUN);
    end
  end

  // LVPECL: sleep forces safe off; distribution power-down applies the own code
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pecl_pd_mode_out <= {NUM_PECL{PECL_PD_SAFE}};
    end else begin
      for (int p = 0; p < NUM_PECL; p++) begin
        if (asleep) begin
          pecl_pd_mode_out[p*2 +: 2] <= PECL_PD_SAFE;
        end else begin
          // 00 normal, 10 protected, 11 unprotected, same in dist power-down
          pecl_pd_mode_out[p*2 +: 2] <= active[IDX_PECL+p][PECL_MODE_LSB +: 2];
        end
      end
    end
  end

  // LVDS/CMOS channels
  // Per-channel decode kept outside the clocked block, no temporaries there
  logic [NUM_CH-1:0] ch_on;
  logic [NUM_CH-1:0] ch_cmos;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      ch_on[c] = !asleep && !dist_off && !active[IDX_LVDS+c][LVDS_PD_BIT];
      ch_cmos[c] = active[IDX_LVDS+c][LVDS_CMOS_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lvds_en_out <= '0;
      lvds_invert_out <= '0;
      cmos_first_en_out <= '0;
      cmos_second_en_out <= '0;
      cmos_pol_out <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        lvds_en_out[c] <= ch_on[c] && !ch_cmos[c];
        lvds_invert_out[c] <= active[IDX_LVDS+c][LVDS_POL_BIT];
        cmos_first_en_out[c] <= ch_on[c] && ch_cmos[c];
        // Second output only follows its own bit while the first is up
        cmos_second_en_out[c] <= ch_on[c] && ch_cmos[c] &&
                                 active[IDX_LVDS+c][CMOS_B_EN_BIT];
        cmos_pol_out[c*3 +: 3] <= active[IDX_LVDS+c][CMOS_POL_LSB +: 3];
      end
    end
  end

  // Read data the cycle after the strobe; shadow copy, unmapped reads zero
  logic [NREG-1:0] rd_hit;
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      rd_hit[i] = (addr_in == reg_addr(i));
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= 8'h00;
      for (int i = 0; i < NREG; i++) begin
        if (rd_hit[i]) rdata_out <= shadow[i];
      end
      if (addr_in == REG_STATUS) rdata_out <= {4'h0, state_q};
    end else begin
      rdata_out <= 8'h00;
    end
  end
endmodule

// [design/clk_ctrl_pkg.sv]
// Package: register offsets, fields, reset values and codes for the power/reset controller
package clk_ctrl_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_CH = 4;
  localparam int NUM_PECL = 4;
  // Register offsets
  localparam logic [9:0] REG_PORT_CFG = 10'h000;
  localparam logic [9:0] REG_PLL_CFG = 10'h010;
  localparam logic [9:0] REG_PECL_BASE = 10'h0F0;
  localparam logic [9:0] REG_LVDS_BASE = 10'h140;
  localparam logic [9:0] REG_BLOCK_PD = 10'h1E0;
  localparam logic [9:0] REG_DIST_CTRL = 10'h230;
  localparam logic [9:0] REG_UPDATE = 10'h232;
  localparam logic [9:0] REG_STATUS = 10'h1F0;
  // Field positions
  localparam int PORT_SRST_LO = 2;
  localparam int PORT_SRST_HI = 5;
  localparam int PLL_MODE_LSB = 0;
  localparam int PECL_MODE_LSB = 0;
  localparam int LVDS_PD_BIT = 0;
  localparam int LVDS_CMOS_BIT = 3;
  localparam int LVDS_POL_BIT = 4;
  localparam int CMOS_POL_LSB = 5;
  localparam int CMOS_B_EN_BIT = 1;
  localparam int DIST_SYNC_BIT = 0;
  localparam int DIST_PD_BIT = 1;
  localparam int BLK_CLK_PD_BIT = 0;
  localparam int BLK_REFERENCE_INPUT_ONE_PD_BIT = 1;
  localparam int BLK_REFERENCE_INPUT_TWO_PD_BIT = 2;
  localparam int UPDATE_BIT = 0;
  // Reset values
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] PLL_CFG_RST = 8'h01;
  localparam logic [7:0] PECL_RST = 8'h08;
  localparam logic [7:0] LVDS_RST = 8'h42;
  localparam logic [7:0] BLOCK_PD_RST = 8'h00;
  localparam logic [7:0] DIST_CTRL_RST = 8'h00;
  // PLL operating modes
  localparam logic [1:0] PLL_NORMAL = 2'h0;
  localparam logic [1:0] PLL_PD_ASYNC = 2'h1;
  localparam logic [1:0] PLL_PD_SYNC = 2'h3;
  // LVPECL power-down codes
  localparam logic [1:0] PECL_NORMAL = 2'h0;
  localparam logic [1:0] PECL_PD_SAFE = 2'h2;
  localparam logic [1:0] PECL_PD_TOTAL = 2'h3;
  // Sync pulse length after wake, in clock cycles
  localparam int SYNC_HOLD_NS = 40;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SYNC_HOLD_CYC = (SYNC_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SEQ_RESET = 4'b0001,
    SEQ_SYNC = 4'b0010,
    SEQ_RUN = 4'b0100,
    SEQ_SLEEP = 4'b1000
  } seq_state_t;
endpackage

// [design/cfg_reg_bank.sv]
// Shadow/active register pair for one configuration byte
module cfg_reg_bank #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic clear_in,
  input wire logic wr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic update_in,
  output logic [WIDTH-1:0] shadow_out,
  output logic [WIDTH-1:0] active_out
);
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      shadow_out <= RST_VAL;
    end else if (clear_in) begin
      shadow_out <= RST_VAL;
    end else if (wr_in) begin
      shadow_out <= wdata_in;
    end
  end

  // Write landing with the update pulse is carried into the active copy too
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_out <= RST_VAL;
    end else if (clear_in) begin
      active_out <= RST_VAL;
    end else if (update_in) begin
      active_out <= wr_in ? wdata_in : shadow_out;
    end
  end
endmodule

// [tb/clk_pwr_props.sv]
// Port checker for the power and reset controller
module clk_pwr_props
  import clk_ctrl_pkg::*;
#(
  parameter int SYNC_CYCLES = 8
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic chip_sleep_pin_n_in,
  input wire logic rd_in,
  input wire logic [clk_ctrl_pkg::DATA_W-1:0] rdata_out,
  input wire logic pll_pd_out,
  input wire logic vco_pd_out,
  input wire logic clk_buf_pd_out,
  input wire logic dividers_pd_out,
  input wire logic [clk_ctrl_pkg::NUM_PECL*2-1:0] pecl_pd_mode_out,
  input wire logic [clk_ctrl_pkg::NUM_CH-1:0] lvds_en_out,
  input wire logic [clk_ctrl_pkg::NUM_CH-1:0] cmos_first_en_out,
  input wire logic [clk_ctrl_pkg::NUM_CH-1:0] cmos_second_en_out,
  input wire logic sync_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  a_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data not zero outside a read");
  a_sleep_off: assert property ((!chip_sleep_pin_n_in)[*8] |=>
    pll_pd_out && vco_pd_out && clk_buf_pd_out && dividers_pd_out && lvds_en_out == '0
    && cmos_first_en_out == '0 && pecl_pd_mode_out == 8'hAA)
    else $error("sleep did not switch blocks off");
  a_b_needs_a: assert property ((cmos_second_en_out & ~cmos_first_en_out) == '0)
    else $error("second CMOS output on without the first");
  a_lvds_or_cmos: assert property ((lvds_en_out & cmos_first_en_out) == '0)
    else $error("channel both LVDS and CMOS");
  a_reset_safe: assert property ($rose(resetn_in) |-> sync_out && lvds_en_out == '0)
    else $error("outputs not held after reset");
  a_wake_sync: assert property ($rose(chip_sleep_pin_n_in) |->
    ##[1:12] sync_out ##[1:30] !sync_out)
    else $error("wake did not run a sync");
  a_sync_ends: assert property ($rose(sync_out) && chip_sleep_pin_n_in |->
    ##[1:30] !sync_out)
    else $error("sync did not end");
  a_vco_tracks: assert property ($rose(pll_pd_out) |-> ##[0:1] vco_pd_out)
    else $error("VCO not off with PLL");
endmodule

bind clk_pwr_ctrl clk_pwr_props #(.SYNC_CYCLES(SYNC_CYCLES)) i_clk_pwr_props (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .chip_sleep_pin_n_in(chip_sleep_pin_n_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .pll_pd_out(pll_pd_out), .vco_pd_out(vco_pd_out),
  .clk_buf_pd_out(clk_buf_pd_out), .dividers_pd_out(dividers_pd_out),
  .pecl_pd_mode_out(pecl_pd_mode_out), .lvds_en_out(lvds_en_out),
  .cmos_first_en_out(cmos_first_en_out), .cmos_second_en_out(cmos_second_en_out),
  .sync_out(sync_out));

// [tb/host_model.sv]
// Host controller model: pins, register port, charge pump pulses
module host_model
  import clk_ctrl_pkg::*;
(
  input wire logic mclk_in,
  output logic resetn_out,
  output logic sleep_n_out,
  output logic cp_event_out,
  output logic [clk_ctrl_pkg::ADDR_W-1:0] addr_out,
  output logic [clk_ctrl_pkg::DATA_W-1:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] exp_q [$];
  initial begin
    resetn_out = 1'h0;
    sleep_n_out = 1'h1;
    cp_event_out = 1'h0;
    addr_out = '0;
    wdata_out = '0;
    wr_out = 1'h0;
    rd_out = 1'h0;
  end
  // Pulse length is ours to pick
  task automatic hard_reset();
    @(posedge mclk_in);
    resetn_out <= 1'h0;
    repeat (4) @(posedge mclk_in);
    resetn_out <= 1'h1;
  endtask
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'h1;
    @(posedge mclk_in);
    wr_out <= 1'h0;
    // Released data lines must not keep the last value
    wdata_out <= ~d;
  endtask
  task automatic read_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge mclk_in);
    addr_out <= a;
    rd_out <= 1'h1;
    exp_q.push_back(e);
    @(posedge mclk_in);
    rd_out <= 1'h0;
  endtask
  // Shadow bytes other than port config go live only here
  task automatic update();
    write_reg(REG_UPDATE, 8'h01);
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
  endtask
  // Bits stay set until written back to zero
  task automatic soft_reset(input logic on);
    write_reg(REG_PORT_CFG, on ? 8'h3C : 8'h18);
  endtask
  task automatic soft_sync();
    write_reg(REG_DIST_CTRL, 8'h01);
    update();
    write_reg(REG_DIST_CTRL, 8'h00);
    update();
  endtask
  task automatic sleep(input logic awake);
    @(posedge mclk_in);
    sleep_n_out <= awake;
  endtask
  task automatic cp_pulse();
    @(posedge mclk_in);
    cp_event_out <= 1'h1;
    @(posedge mclk_in);
    cp_event_out <= 1'h0;
    repeat (2) @(negedge mclk_in);
  endtask
endmodule

// [tb/tb_clk_pwr_ctrl.sv]
// Self-checking bench for the power and reset controller
module tb_clk_pwr_ctrl
  import clk_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SC = 2;
  logic mclk_in, resetn, sleep_n, cp_ev, wr, rd, rd_prev, sync_prev, sync_out;
  logic pll_pd, vco_pd, clk_pd, r1_pd, r2_pd, div_pd, bias_off;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [7:0] pecl;
  logic [7:0] cfg [4];
  logic [3:0] lvds_en, lvds_inv, a_en, b_en;
  logic [11:0] pol;
  logic [1:0] codes [3] = '{PECL_PD_SAFE, PECL_PD_TOTAL, PECL_NORMAL};
  logic [9:0] ra [9] = '{10'h000, 10'h010, 10'h0F0, 10'h0F3, 10'h140, 10'h143, 10'h1E0,
    10'h230, 10'h1F0};
  logic [7:0] rv [9] = '{8'h18, 8'h01, 8'h08, 8'h08, 8'h42, 8'h42, 8'h00, 8'h00, 8'h04};
  int mismatches, tests_run, cycles, syncs, n;
  integer seed;
  clk_pwr_ctrl #(.SYNC_CYCLES(SC)) i_clk_pwr_ctrl (
    .mclk_in(mclk_in), .resetn_in(resetn), .chip_sleep_pin_n_in(sleep_n),
    .cp_event_in(cp_ev), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .pll_pd_out(pll_pd), .vco_pd_out(vco_pd), .clk_buf_pd_out(clk_pd),
    .ref_one_pd_out(r1_pd), .ref_two_pd_out(r2_pd), .dividers_pd_out(div_pd),
    .dist_bias_off_out(bias_off), .pecl_pd_mode_out(pecl), .lvds_en_out(lvds_en),
    .lvds_invert_out(lvds_inv), .cmos_first_en_out(a_en), .cmos_second_en_out(b_en),
    .cmos_pol_out(pol), .sync_out(sync_out));
  host_model i_host_model (.mclk_in(mclk_in), .resetn_out(resetn), .sleep_n_out(sleep_n),
    .cp_event_out(cp_ev), .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  initial begin
    mclk_in = 1'h0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic chk(input string name, input logic [11:0] e, input logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Sync may already be running when we start looking; both waits are bounded
  task automatic wait_run();
    for (int k = 0; k < 20 && sync_out !== 1'h1; k++) @(negedge mclk_in);
    chk("sync_seen", 12'h001, sync_out);
    for (int k = 0; k < 60 && sync_out !== 1'h0; k++) @(negedge mclk_in);
    chk("sync_out", 12'h000, sync_out);
  endtask
  task automatic check_ch();
    for (int i = 0; i < 4; i++) begin
      chk("lvds_en", !cfg[i][0] && !cfg[i][3], lvds_en[i]);
      chk("lvds_inv", cfg[i][4], lvds_inv[i]);
      chk("cmos_a", !cfg[i][0] && cfg[i][3], a_en[i]);
      chk("cmos_b", !cfg[i][0] && cfg[i][3] && cfg[i][1], b_en[i]);
      chk("cmos_pol", cfg[i][7:5], pol[3*i+:3]);
    end
  endtask
  always @(posedge mclk_in) begin
    rd_prev <= rd;
    sync_prev <= sync_out;
    if (sync_out === 1'h1 && sync_prev === 1'h0) syncs <= syncs + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  always @(negedge mclk_in) begin
    if (rd_prev === 1'h1) chk("rdata", i_host_model.exp_q.pop_front(), rdata);
  end
  initial begin
    seed = 32'h6a23_4399;
    i_host_model.hard_reset();
    wait_run();
    chk("pll_pd", 12'h001, pll_pd);
    chk("lvds_en", 12'h00F, lvds_en);
    for (int i = 0; i < 9; i++) i_host_model.read_reg(ra[i], rv[i]);
    i_host_model.read_reg(10'h3FF, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cfg[i] = 8'($random(seed));
      cfg[i][3] = i[0];
      cfg[i][1] = i[1];
      cfg[i][0] = (i == 2);
      i_host_model.write_reg(REG_LVDS_BASE + 10'(i), cfg[i]);
    end
    @(negedge mclk_in);
    chk("lvds_en", 12'h00F, lvds_en);
    i_host_model.update();
    check_ch();
    foreach (codes[c]) begin
      for (int i = 0; i < 4; i++) i_host_model.write_reg(REG_PECL_BASE + 10'(i), {6'h02, codes[c]});
      i_host_model.update();
      chk("pecl", {4{codes[c]}}, pecl);
    end
    i_host_model.write_reg(REG_BLOCK_PD, 8'h05);
    i_host_model.write_reg(REG_DIST_CTRL, 8'h02);
    i_host_model.update();
    chk("blocks", 12'h005, {r2_pd, r1_pd, clk_pd});
    chk("bias_off", 12'h001, bias_off);
    n = syncs;
    i_host_model.write_reg(REG_DIST_CTRL, 8'h00);
    i_host_model.update();
    wait_run();
    chk("syncs", 12'(n + 1), 12'(syncs));
    i_host_model.write_reg(REG_PLL_CFG, {6'h00, PLL_NORMAL});
    i_host_model.update();
    chk("pll_pd", 12'h000, pll_pd);
    i_host_model.write_reg(REG_PLL_CFG, {6'h00, PLL_PD_SYNC});
    i_host_model.update();
    chk("pll_pd", 12'h000, pll_pd);
    i_host_model.cp_pulse();
    chk("pll_pd", 12'h001, pll_pd);
    i_host_model.write_reg(REG_PLL_CFG, {6'h00, PLL_NORMAL});
    i_host_model.update();
    chk("pll_pd", 12'h000, pll_pd);
    i_host_model.write_reg(REG_PLL_CFG, {6'h00, PLL_PD_ASYNC});
    i_host_model.update();
    chk("pll_pd", 12'h001, pll_pd);
    i_host_model.sleep(1'h0);
    repeat (8) @(negedge mclk_in);
    chk("sleep_pd", 12'h00F, {pll_pd, vco_pd, clk_pd, div_pd});
    chk("sleep_en", 12'h000, {lvds_en, a_en, b_en});
    chk("sleep_pecl", 12'h0AA, pecl);
    i_host_model.write_reg(REG_LVDS_BASE, 8'h0B);
    i_host_model.update();
    i_host_model.read_reg(REG_STATUS, 8'h08);
    i_host_model.read_reg(REG_LVDS_BASE, 8'h0B);
    i_host_model.sleep(1'h1);
    wait_run();
    cfg[0] = 8'h0B;
    check_ch();
    chk("clk_pd", 12'h001, clk_pd);
    i_host_model.soft_sync();
    i_host_model.soft_reset(1'h1);
    i_host_model.read_reg(REG_LVDS_BASE, 8'h42);
    i_host_model.soft_reset(1'h0);
    wait_run();
    chk("lvds_en", 12'h00F, lvds_en);
    chk("clk_pd", 12'h000, clk_pd);
    i_host_model.write_reg(REG_DIST_CTRL, 8'h02);
    i_host_model.update();
    i_host_model.hard_reset();
    wait_run();
    chk("bias_off", 12'h000, bias_off);
    i_host_model.read_reg(REG_DIST_CTRL, 8'h00);
    repeat (2) @(negedge mclk_in);
    give_verdict();
  end
endmodule
